// >>> core/rtcta_pkg.sv
// Package with register map, field positions, reset values and state codes of the timer block.
package rtcta_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned TMR_W = 32;

    // Register byte addresses on the Wishbone bus.
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_SNAPSHOT = 8'h08;
    localparam logic [7:0] OFS_MATCH = 8'h0c;
    localparam logic [7:0] OFS_ROUTE = 8'h10;

    // Field positions of rtc_control.
    localparam int unsigned BIT_OSC_ENABLE = 7;
    localparam int unsigned BIT_MISS_DETECT = 6;
    localparam int unsigned BIT_OSC_FAIL = 5;
    localparam int unsigned BIT_TIMER_RUN = 4;
    localparam int unsigned BIT_ALARM_ENABLE = 3;
    localparam int unsigned BIT_ALARM_FLAG = 2;
    localparam int unsigned BIT_LOAD_GO = 1;
    localparam int unsigned BIT_SNAP_GO = 0;

    // Field positions of the alarm routing register.
    localparam int unsigned BIT_ROUTE_RESET = 0;
    localparam int unsigned BIT_ROUTE_WAKE = 1;
    localparam int unsigned BIT_ROUTE_IRQ = 2;

    // Values after reset, and the step added to the timer per count.
    localparam logic [31:0] RST_TIMER = 32'h0000_0000;
    localparam logic [31:0] RST_SNAPSHOT = 32'h0000_0000;
    localparam logic [31:0] RST_MATCH = 32'h0000_0000;
    localparam logic [2:0] RST_ROUTE = 3'h0;
    localparam logic [31:0] TIMER_ONE = 32'h0000_0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_SNAP = 3'b100
    } rtcta_xfer_t;

endpackage

// >>> core/rtcta_tmr_if.sv
// Interface joining the register side to the timer counter.
interface rtcta_tmr_if;
    logic tick;
    logic run;
    logic load;
    logic [31:0] load_val;
    logic [31:0] match_val;
    logic autoreset;
    logic alarm_en;
    logic [31:0] value;
    logic flag;

    modport ctrl (output tick, run, load, load_val, match_val, autoreset, alarm_en,
                  input value, flag);
    modport timer (input tick, run, load, load_val, match_val, autoreset, alarm_en,
                   output value, flag);
endinterface

// >>> core/rtcta_timer.sv
// Timer counter with alarm comparator, auto reset and self-clearing alarm flag.
module rtcta_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register side
    rtcta_tmr_if.timer tif
);

    typedef struct packed {
        logic [31:0] value;
        logic flag;
    } rtcta_tstate_t;

    rtcta_tstate_t s;
    rtcta_tstate_t next_s;
    logic ev;

    always_comb begin
        next_s = s;
        ev = 1'b0;
        if (tif.tick) begin
            if (tif.load) begin
                next_s.value = tif.load_val;
            end else if (tif.autoreset && s.flag) begin
                next_s.value = rtcta_pkg::RST_TIMER;
            end else if (tif.run) begin
                // Plain unsigned add wraps from all ones to zero.
                next_s.value = s.value + rtcta_pkg::TIMER_ONE;
            end
            // Only a change of value or a load can match, so a stopped timer never re-fires.
            ev = tif.alarm_en && (next_s.value == tif.match_val)
                 && (tif.load || next_s.value != s.value);
        end
        if (!tif.alarm_en) begin
            next_s.flag = 1'b0;
        end else if (ev) begin
            next_s.flag = 1'b1;
        end else if (tif.tick) begin
            next_s.flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tif.value = s.value;
    assign tif.flag = s.flag;

    a_timer_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        tif.tick && tif.run && !tif.load && !(tif.autoreset && s.flag)
        && s.value == 32'hffff_ffff |=> s.value == 32'h0000_0000)
        else $error("timer did not wrap to zero");
    a_auto_reset: assert property (@(posedge clk) disable iff (!rst_b)
        tif.tick && s.flag && tif.autoreset && !tif.load |=> s.value == 32'h0000_0000)
        else $error("auto reset did not clear timer");
    a_flag_short: assert property (@(posedge clk) disable iff (!rst_b)
        s.flag && tif.tick && !ev |=> !s.flag)
        else $error("alarm flag outlived one oscillator cycle");
    a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_b)
        tif.tick && !tif.run && !tif.load && !(tif.autoreset && s.flag) |=> $stable(s.value))
        else $error("stopped timer changed");
    a_load_value: assert property (@(posedge clk) disable iff (!rst_b)
        tif.tick && tif.load |=> s.value == $past(tif.load_val))
        else $error("load value not taken");
    c_wrap: cover property (@(posedge clk) disable iff (!rst_b)
        tif.tick && s.value == 32'hffff_ffff ##1 s.value == 32'h0000_0000);

endmodule

// >>> core/rtcta_core.sv
// Top of the timer block: Wishbone register slave, transfer control and alarm routing.
//
// Functional notes
// - Timer reached through one snapshot register word.
// - Load and snapshot work while counting.
// - Load go copies snapshot into timer.
// - Hardware clears load go after transfer.
// - Snapshot go copies timer, then clears.
// - Alarm event when timer equals match.
// - Auto reset zeroes timer one tick later.
// - Alarm routable to reset, wake, interrupt.
// - Clearing alarm enable clears alarm flag.
// - Unchanged match refires after wrap or a load.
// - Alarm flag lasts at most one tick.
// - Timer wraps to zero, keeps counting.
// - Control bit 7 switches oscillator on.
// - Hardware sets oscillator fail, software clears.
// - Run bit increments timer, else holds.
// - Flag bit reads event, writes auto reset.
//
// Our own choice: register access over Wishbone.
module rtcta_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack,
    // Timer oscillator
    input wire logic osc_tick,
    input wire logic miss_clk_event,
    output logic osc_enable,
    output logic miss_detect_enable,
    // Alarm routing
    output logic alarm_reset_req,
    output logic alarm_wake_req,
    output logic alarm_irq_req
);

    typedef struct packed {
        rtcta_pkg::rtcta_xfer_t st;
        logic osc_en;
        logic miss_en;
        logic osc_fail;
        logic run;
        logic alarm_en;
        logic autoreset;
        logic load_go;
        logic snap_go;
        logic [31:0] snapshot_regs;
        logic [31:0] match_regs;
        logic [2:0] route;
        logic ack;
        logic [31:0] rdata;
        logic rst_req;
        logic wake_req;
        logic irq_req;
    } rtcta_cstate_t;

    rtcta_cstate_t s;
    rtcta_cstate_t next_s;
    rtcta_tmr_if tif ();

    logic tick_eff;
    logic req;
    logic wr;
    logic [7:0] ctl_rd;
    logic ctl_wr;
    logic snp_wr;

    // Without the oscillator enabled no timer cycle exists at all.
    assign tick_eff = osc_tick & s.osc_en;
    assign req = wb_cyc & wb_stb & ~s.ack;
    assign wr = req & wb_we;
    // Write decodes watched by the checks at the end of the module.
    assign ctl_wr = wr & (wb_adr == rtcta_pkg::OFS_CONTROL) & wb_sel[0];
    assign snp_wr = wr & (wb_adr == rtcta_pkg::OFS_SNAPSHOT);

    assign ctl_rd = {s.osc_en, s.miss_en, s.osc_fail, s.run, s.alarm_en,
                     tif.flag, s.load_go, s.snap_go};

    rtcta_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tif(tif)
    );

    assign tif.tick = tick_eff;
    assign tif.run = s.run;
    assign tif.load = (s.st == rtcta_pkg::ST_LOAD);
    assign tif.load_val = s.snapshot_regs;
    assign tif.match_val = s.match_regs;
    assign tif.autoreset = s.autoreset;
    assign tif.alarm_en = s.alarm_en;

    always_comb begin
        next_s = s;
        next_s.ack = req;
        next_s.rdata = s.rdata;

        // Register writes; the snapshot word is locked while a transfer is pending.
        if (wr) begin
            case (wb_adr)
                rtcta_pkg::OFS_CONTROL: begin
                    if (wb_sel[0]) begin
                        next_s.osc_en = wb_dat_i[rtcta_pkg::BIT_OSC_ENABLE];
                        next_s.miss_en = wb_dat_i[rtcta_pkg::BIT_MISS_DETECT];
                        next_s.run = wb_dat_i[rtcta_pkg::BIT_TIMER_RUN];
                        next_s.alarm_en = wb_dat_i[rtcta_pkg::BIT_ALARM_ENABLE];
                        next_s.autoreset = wb_dat_i[rtcta_pkg::BIT_ALARM_FLAG];
                        if (!wb_dat_i[rtcta_pkg::BIT_OSC_FAIL]) begin
                            next_s.osc_fail = 1'b0;
                        end
                        if (wb_dat_i[rtcta_pkg::BIT_LOAD_GO]) begin
                            next_s.load_go = 1'b1;
                        end
                        if (wb_dat_i[rtcta_pkg::BIT_SNAP_GO]) begin
                            next_s.snap_go = 1'b1;
                        end
                    end
                end
                rtcta_pkg::OFS_SNAPSHOT: begin
                    if (s.st == rtcta_pkg::ST_IDLE && !s.load_go && !s.snap_go) begin
                        for (int b = 0; b < 4; b++) begin
                            if (wb_sel[b]) begin
                                next_s.snapshot_regs[8*b +: 8] = wb_dat_i[8*b +: 8];
                            end
                        end
                    end
                end
                rtcta_pkg::OFS_MATCH: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel[b]) begin
                            next_s.match_regs[8*b +: 8] = wb_dat_i[8*b +: 8];
                        end
                    end
                end
                rtcta_pkg::OFS_ROUTE: begin
                    if (wb_sel[0]) begin
                        next_s.route = wb_dat_i[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses answer with zero.
        if (req) begin
            case (wb_adr)
                rtcta_pkg::OFS_CONTROL: next_s.rdata = {24'h00_0000, ctl_rd};
                rtcta_pkg::OFS_SNAPSHOT: next_s.rdata = s.snapshot_regs;
                rtcta_pkg::OFS_MATCH: next_s.rdata = s.match_regs;
                rtcta_pkg::OFS_ROUTE: next_s.rdata = {29'h0000_0000, s.route};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Hardware set of the failure flag wins over a software clear in the same cycle.
        if (miss_clk_event && s.miss_en && s.osc_en) begin
            next_s.osc_fail = 1'b1;
        end

        // Transfer sequencer; a load queued together with a snapshot runs first.
        case (s.st)
            rtcta_pkg::ST_IDLE: begin
                if (s.load_go) begin
                    next_s.st = rtcta_pkg::ST_LOAD;
                end else if (s.snap_go) begin
                    next_s.st = rtcta_pkg::ST_SNAP;
                end
            end
            rtcta_pkg::ST_LOAD: begin
                // The copy lands on a timer cycle boundary, so the count never tears.
                if (tick_eff) begin
                    next_s.load_go = 1'b0;
                    next_s.st = rtcta_pkg::ST_IDLE;
                end
            end
            rtcta_pkg::ST_SNAP: begin
                // Whole word taken in one clock while the timer keeps running.
                next_s.snapshot_regs = tif.value;
                next_s.snap_go = 1'b0;
                next_s.st = rtcta_pkg::ST_IDLE;
            end
            default: begin
                next_s.st = rtcta_pkg::ST_IDLE;
            end
        endcase

        next_s.rst_req = tif.flag & s.route[rtcta_pkg::BIT_ROUTE_RESET];
        next_s.wake_req = tif.flag & s.route[rtcta_pkg::BIT_ROUTE_WAKE];
        next_s.irq_req = tif.flag & s.route[rtcta_pkg::BIT_ROUTE_IRQ];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s.st <= rtcta_pkg::ST_IDLE;
            s.osc_en <= 1'b0;
            s.miss_en <= 1'b0;
            s.osc_fail <= 1'b0;
            s.run <= 1'b0;
            s.alarm_en <= 1'b0;
            s.autoreset <= 1'b0;
            s.load_go <= 1'b0;
            s.snap_go <= 1'b0;
            s.snapshot_regs <= rtcta_pkg::RST_SNAPSHOT;
            s.match_regs <= rtcta_pkg::RST_MATCH;
            s.route <= rtcta_pkg::RST_ROUTE;
            s.ack <= 1'b0;
            s.rdata <= 32'h0000_0000;
            s.rst_req <= 1'b0;
            s.wake_req <= 1'b0;
            s.irq_req <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack = s.ack;
    assign wb_dat_o = s.rdata;
    assign osc_enable = s.osc_en;
    assign miss_detect_enable = s.miss_en;
    assign alarm_reset_req = s.rst_req;
    assign alarm_wake_req = s.wake_req;
    assign alarm_irq_req = s.irq_req;

    a_ack_single: assert property (@(posedge clk) disable iff (!rst_b)
        s.ack |=> !s.ack)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property (@(posedge clk) disable iff (!rst_b)
        req |=> s.ack)
        else $error("request not answered in the next cycle");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
        req && !wb_we && wb_adr > rtcta_pkg::OFS_ROUTE |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_load_go_clear: assert property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_LOAD && tick_eff
        |=> !s.load_go && tif.value == $past(s.snapshot_regs))
        else $error("load go not cleared with timer loaded");

    a_load_first: assert property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_IDLE && s.load_go |=> s.st == rtcta_pkg::ST_LOAD)
        else $error("queued load did not start");

    a_load_go_wait: assert property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_LOAD && !tick_eff |=> s.load_go)
        else $error("load go cleared before the timer took the value");

    a_snap_capture: assert property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_SNAP |=> !s.snap_go && s.snapshot_regs == $past(tif.value))
        else $error("snapshot did not take timer value");

    a_snap_start: assert property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_IDLE && s.snap_go && !s.load_go |=> s.st == rtcta_pkg::ST_SNAP)
        else $error("queued snapshot did not start");

    a_snap_bounded: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(s.snap_go) && !s.load_go |-> ##[1:3] !s.snap_go)
        else $error("snapshot go stuck");

    a_snap_locked: assert property (@(posedge clk) disable iff (!rst_b)
        snp_wr && (s.load_go || s.snap_go) && s.st != rtcta_pkg::ST_SNAP
        |=> $stable(s.snapshot_regs))
        else $error("snapshot word changed during a transfer");

    a_alarm_match: assert property (@(posedge clk) disable iff (!rst_b)
        tick_eff && s.run && s.alarm_en && s.st != rtcta_pkg::ST_LOAD
        && !(s.autoreset && tif.flag) && tif.value + 32'h1 == s.match_regs |=> tif.flag)
        else $error("alarm flag missing at match");

    a_disable_clears: assert property (@(posedge clk) disable iff (!rst_b)
        !s.alarm_en |=> !tif.flag)
        else $error("alarm flag survived disable");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr |=> s.alarm_en == $past(wb_dat_i[rtcta_pkg::BIT_ALARM_ENABLE]))
        else $error("alarm enable not written");

    a_autoreset_write: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr |=> s.autoreset == $past(wb_dat_i[rtcta_pkg::BIT_ALARM_FLAG]))
        else $error("auto reset enable not written");

    a_ctl_readback: assert property (@(posedge clk) disable iff (!rst_b)
        req && !wb_we && wb_adr == rtcta_pkg::OFS_CONTROL
        |=> wb_dat_o[rtcta_pkg::BIT_ALARM_FLAG] == $past(tif.flag))
        else $error("flag bit did not read the alarm event");

    a_run_bit: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr |=> s.run == $past(wb_dat_i[rtcta_pkg::BIT_TIMER_RUN]))
        else $error("run bit not written");

    a_osc_enable_out: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr |=> osc_enable == $past(wb_dat_i[rtcta_pkg::BIT_OSC_ENABLE]))
        else $error("oscillator enable not written");

    a_no_tick_off: assert property (@(posedge clk) disable iff (!rst_b)
        !s.osc_en && s.st == rtcta_pkg::ST_IDLE |=> $stable(tif.value))
        else $error("timer moved with oscillator off");

    a_fail_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        miss_clk_event && s.miss_en && s.osc_en |=> s.osc_fail)
        else $error("oscillator fail not set");

    a_fail_hold: assert property (@(posedge clk) disable iff (!rst_b)
        s.osc_fail && !ctl_wr |=> s.osc_fail)
        else $error("oscillator fail cleared without software");

    a_fail_clear: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr && !wb_dat_i[rtcta_pkg::BIT_OSC_FAIL]
        && !(miss_clk_event && s.miss_en && s.osc_en) |=> !s.osc_fail)
        else $error("oscillator fail not cleared by software");

    a_route_reset: assert property (@(posedge clk) disable iff (!rst_b)
        tif.flag && s.route[rtcta_pkg::BIT_ROUTE_RESET] |=> alarm_reset_req)
        else $error("alarm not routed to reset");

    a_route_wake: assert property (@(posedge clk) disable iff (!rst_b)
        tif.flag && s.route[rtcta_pkg::BIT_ROUTE_WAKE] |=> alarm_wake_req)
        else $error("alarm not routed to wake");

    a_route_irq: assert property (@(posedge clk) disable iff (!rst_b)
        tif.flag && s.route[rtcta_pkg::BIT_ROUTE_IRQ] |=> alarm_irq_req)
        else $error("alarm not routed to interrupt");

    a_route_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !tif.flag |=> !alarm_reset_req && !alarm_wake_req && !alarm_irq_req)
        else $error("alarm request without alarm event");

    c_load_done: cover property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_LOAD ##1 s.st == rtcta_pkg::ST_IDLE);
    c_snap_done: cover property (@(posedge clk) disable iff (!rst_b)
        s.st == rtcta_pkg::ST_SNAP ##1 !s.snap_go);
    c_alarm_auto: cover property (@(posedge clk) disable iff (!rst_b)
        tif.flag && s.autoreset ##[1:4] tif.value == 32'h0000_0000);
    c_fail_set: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(s.osc_fail));

endmodule

// >>> bench/rtcta_core_test.sv
// Self-checking testbench of the timer block, driven over its Wishbone register port.
module rtcta_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] C_OSC = 32'h1 << rtcta_pkg::BIT_OSC_ENABLE;
    localparam logic [31:0] C_MD = 32'h1 << rtcta_pkg::BIT_MISS_DETECT;
    localparam logic [31:0] C_FAIL = 32'h1 << rtcta_pkg::BIT_OSC_FAIL;
    localparam logic [31:0] C_RUN = 32'h1 << rtcta_pkg::BIT_TIMER_RUN;
    localparam logic [31:0] C_AEN = 32'h1 << rtcta_pkg::BIT_ALARM_ENABLE;
    localparam logic [31:0] C_AR = 32'h1 << rtcta_pkg::BIT_ALARM_FLAG;
    localparam logic [31:0] C_LOAD = 32'h1 << rtcta_pkg::BIT_LOAD_GO;
    localparam logic [31:0] C_SNAP = 32'h1 << rtcta_pkg::BIT_SNAP_GO;
    localparam logic [7:0] A_CTL = rtcta_pkg::OFS_CONTROL;
    localparam logic [7:0] A_SNP = rtcta_pkg::OFS_SNAPSHOT;
    localparam logic [31:0] M = 32'h0000_0100;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic osc_tick = 1'b0;
    logic miss_clk_event = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack;
    logic osc_enable;
    logic miss_detect_enable;
    logic alarm_reset_req;
    logic alarm_wake_req;
    logic alarm_irq_req;
    logic [31:0] ctl = 32'h0;
    logic [31:0] rd;
    logic [31:0] route_seen;
    logic [3:0] lane_sel = 4'hf;
    int error_cnt = 0;
    int n_tests = 0;

    assign route_seen = {29'h0, alarm_irq_req, alarm_wake_req, alarm_reset_req};

    always #10 clk = ~clk;

    rtcta_core rtcta_core_inst (
        .clk(clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack(wb_ack), .osc_tick(osc_tick), .miss_clk_event(miss_clk_event),
        .osc_enable(osc_enable), .miss_detect_enable(miss_detect_enable),
        .alarm_reset_req(alarm_reset_req), .alarm_wake_req(alarm_wake_req),
        .alarm_irq_req(alarm_irq_req)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request stands until the rising edge at which ack is sampled high; read data is
    // taken and the request released at that same edge, so no half cycle is relied on.
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_i <= dat;
        wb_sel <= lane_sel;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        check("wb_ack", {31'h0, wb_ack}, 32'h1);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        xfer(1'b1, adr, dat);
    endtask

    task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] mask,
                         input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        check(name, rd & mask, exp);
    endtask

    task automatic setctl(input logic [31:0] v);
        ctl = v;
        wr(A_CTL, v);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            osc_tick <= 1'b1;
            @(posedge clk);
            osc_tick <= 1'b0;
        end
    endtask

    task automatic miss_pulse();
        @(posedge clk);
        miss_clk_event <= 1'b1;
        @(posedge clk);
        miss_clk_event <= 1'b0;
    endtask

    task automatic load(input logic [31:0] v);
        wr(A_SNP, v);
        wr(A_CTL, ctl | C_LOAD);
        tick(1);
    endtask

    task automatic snap(input logic [31:0] exp);
        int n;
        wr(A_CTL, ctl | C_SNAP);
        n = 0;
        do begin
            xfer(1'b0, A_CTL, 32'h0);
            n++;
        end while (rd[rtcta_pkg::BIT_SNAP_GO] !== 1'b0 && n < 10);
        check("snap_go", rd & C_SNAP, 32'h0);
        rdchk("snapshot", A_SNP, 32'hffff_ffff, exp);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rdchk("ctl_rst", A_CTL, 32'hff, 32'h0);
        rdchk("snp_rst", A_SNP, 32'hffff_ffff, rtcta_pkg::RST_SNAPSHOT);
        rdchk("mat_rst", rtcta_pkg::OFS_MATCH, 32'hffff_ffff, rtcta_pkg::RST_MATCH);
        rdchk("rte_rst", rtcta_pkg::OFS_ROUTE, 32'h7, 32'h0);
        wr(8'h20, 32'hffff_ffff);
        rdchk("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
        $display("test reset done");

        setctl(C_OSC | C_RUN);
        check("osc_enable", {31'h0, osc_enable}, 32'h1);
        wr(A_SNP, 32'h1234_5678);
        wr(A_CTL, ctl | C_LOAD);
        rdchk("load_busy", A_CTL, 32'hff, ctl | C_LOAD);
        wr(A_SNP, 32'hdead_beef);
        tick(1);
        rdchk("load_done", A_CTL, 32'hff, ctl);
        tick(3);
        snap(32'h1234_567b);
        load(32'hffff_fffe);
        tick(3);
        snap(32'h0000_0001);
        setctl(C_RUN);
        check("osc_off", {31'h0, osc_enable}, 32'h0);
        tick(2);
        snap(32'h0000_0001);
        $display("test load and snapshot done");

        setctl(C_OSC | C_RUN);
        wr(rtcta_pkg::OFS_MATCH, M);
        setctl(C_OSC | C_RUN | C_AEN);
        for (int i = 0; i < 3; i++) begin
            wr(rtcta_pkg::OFS_ROUTE, 32'h1 << i);
            load(M - 32'h2);
            tick(1);
            rdchk("flag_early", A_CTL, C_AR, 32'h0);
            tick(1);
            rdchk("flag_match", A_CTL, 32'hff, ctl | C_AR);
            check("route", route_seen, 32'h1 << i);
            tick(1);
            rdchk("flag_gone", A_CTL, C_AR, 32'h0);
            check("route_off", route_seen, 32'h0);
        end
        $display("test alarm routing done");

        load(M - 32'h1);
        tick(1);
        setctl(C_OSC | C_RUN);
        rdchk("flag_aen_off", A_CTL, 32'hff, ctl);
        setctl(C_OSC | C_AEN);
        tick(1);
        rdchk("no_refire", A_CTL, C_AR, 32'h0);
        snap(M);
        $display("test alarm disable done");

        setctl(C_OSC | C_RUN | C_AEN | C_AR);
        load(M - 32'h1);
        tick(1);
        rdchk("ar_flag", A_CTL, 32'hff, ctl);
        tick(1);
        rdchk("ar_reads_flag", A_CTL, 32'hff, C_OSC | C_RUN | C_AEN);
        snap(32'h0);
        tick(2);
        snap(32'h2);
        $display("test auto reset done");

        setctl(C_OSC | C_RUN);
        miss_pulse();
        rdchk("fail_off", A_CTL, 32'hff, ctl);
        setctl(C_OSC | C_MD);
        check("md_enable", {31'h0, miss_detect_enable}, 32'h1);
        miss_pulse();
        rdchk("fail_set", A_CTL, 32'hff, ctl | C_FAIL);
        setctl(C_OSC | C_MD);
        rdchk("fail_clr", A_CTL, 32'hff, ctl);
        $display("test oscillator fail done");

        lane_sel = 4'h6;
        wr(A_SNP, 32'haabb_ccdd);
        lane_sel = 4'hf;
        rdchk("snp_lanes", A_SNP, 32'hffff_ffff, 32'h00bb_cc02);
        $display("test byte lanes done");
        summarize();
    end
endmodule
